// file: common/psc_pkg.sv
package psc_pkg;

  // Register byte offsets
  localparam logic [7:0] PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG = 8'h20;
  localparam logic [7:0] PSC_OFF_SEQUENCE_STATE_REPORT = 8'h24;
  localparam logic [7:0] PSC_OFF_CONVERTER_CONTROL = 8'h2c;
  localparam logic [7:0] PSC_OFF_INT_STATUS = 8'h60;
  localparam logic [7:0] PSC_OFF_INT_CLEAR = 8'h64;
  localparam logic [7:0] PSC_OFF_INT_ENABLE = 8'h68;
  localparam logic [7:0] PSC_OFF_SEQ_CONTROL = 8'h6c;

  // Supply setting layout, shared by config and report
  localparam int PSC_BIT_CORE_EN = 0;
  localparam int PSC_BIT_ANALOGUE_EN = 1;
  localparam int PSC_BIT_PLL_EN = 4;
  localparam int PSC_BIT_IO_EN = 5;
  localparam int PSC_BIT_CORE_PFM = 8;
  localparam int PSC_BIT_ANALOGUE_PFM = 9;
  localparam int PSC_BIT_TILE_STOP = 14;
  localparam int PSC_DWELL_LSB = 16;
  localparam int PSC_DWELL_MSB = 20;
  localparam logic [14:0] PSC_SETTING_MASK = 15'h4333;

  localparam logic [31:0] PSC_CFG_WRITE_MASK = 32'h001f4331;
  localparam logic [31:0] PSC_CFG_RESET = 32'h00100002;
  localparam logic [31:0] PSC_CFG_FIXED_ONES = 32'h00000002;

  // Report fields
  localparam int PSC_REP_STATE_LSB = 16;
  localparam logic [3:0] PSC_PREV_EN_RESET = 4'h2;

  // Converter control fields
  localparam int PSC_CC_CORE_CLK_LSB = 0;
  localparam int PSC_CC_CORE_ILIM_LSB = 5;
  localparam int PSC_CC_ANA_CLK_LSB = 8;
  localparam int PSC_CC_ANA_ILIM_LSB = 13;
  localparam int PSC_CC_ERR_CLEAR = 16;
  localparam int PSC_CC_PGOOD_LSB = 24;
  localparam logic [31:0] PSC_CC_WRITE_MASK = 32'h03016363;
  localparam logic [31:0] PSC_CC_RESET = 32'h02000101;

  // Settings applied in states other than the second sleep phase
  localparam logic [14:0] PSC_SET_RESET = 15'h0000;
  localparam logic [14:0] PSC_SET_ASLEEP = 15'h0000;
  localparam logic [14:0] PSC_SET_WAKING1 = 15'h0020;
  localparam logic [14:0] PSC_SET_WAKING2 = 15'h0033;
  localparam logic [14:0] PSC_SET_AWAKE = 15'h0033;
  localparam logic [14:0] PSC_SET_SLEEPING1 = 15'h0022;

  // Interrupt layout
  localparam int PSC_INT_W = 3;
  localparam int PSC_INT_STATE_CHANGE = 0;
  localparam int PSC_INT_CORE_ERROR = 1;
  localparam int PSC_INT_ANALOGUE_ERROR = 2;
  localparam logic [2:0] PSC_INT_RESET = 3'h0;
  localparam int PSC_CTRL_SLEEP_REQ = 0;

  // Reported state codes
  localparam logic [2:0] PSC_CODE_RESET = 3'h0;
  localparam logic [2:0] PSC_CODE_ASLEEP = 3'h1;
  localparam logic [2:0] PSC_CODE_WAKING1 = 3'h2;
  localparam logic [2:0] PSC_CODE_WAKING2 = 3'h3;
  localparam logic [2:0] PSC_CODE_AWAKE_WAIT = 3'h4;
  localparam logic [2:0] PSC_CODE_AWAKE = 3'h5;
  localparam logic [2:0] PSC_CODE_SLEEPING1 = 3'h6;
  localparam logic [2:0] PSC_CODE_SECOND_SLEEP = 3'h7;

  localparam int PSC_SYNC_W = 6;

  // Gray codes along reset, wake, awake, sleep, asleep
  typedef enum logic [2:0] {
    PSC_ST_RESET = 3'b000,
    PSC_ST_WAKING1 = 3'b001,
    PSC_ST_WAKING2 = 3'b011,
    PSC_ST_AWAKE_WAIT = 3'b010,
    PSC_ST_AWAKE = 3'b110,
    PSC_ST_SLEEPING1 = 3'b111,
    PSC_ST_SECOND_SLEEP_PHASE = 3'b101,
    PSC_ST_ASLEEP = 3'b100
  } psc_state_e;

endpackage : psc_pkg

// file: verilog/psc_power_sequence_control.sv
`timescale 1ns/10ps
module psc_power_sequence_control import psc_pkg::*; #(
  parameter int OTHER_DWELL_LOG2 = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic coreGood,
  input wire logic analogueGood,
  input wire logic pllGood,
  input wire logic ioSupplyGood,
  input wire logic coreBuckError,
  input wire logic analogueBuckError,
  output logic coreBuckEnable,
  output logic analogueBuckEnable,
  output logic pllSupplyRegulatorEnable,
  output logic ioSupplyOutputEnable,
  output logic coreModulationPfm,
  output logic analogueModulationPfm,
  output logic tileClockStop,
  output logic [1:0] powerGoodLevel,
  output logic converterErrorClear,
  output logic [1:0] analogueCurrentLimit,
  output logic [1:0] analogueSwitchClock,
  output logic [1:0] coreCurrentLimit,
  output logic [1:0] coreSwitchClock,
  output logic irq
);

  psc_state_e state;
  psc_state_e nextState;
  logic [31:0] sleepCfg;
  logic [31:0] convCtrl;
  logic [14:0] applied;
  logic [14:0] next_applied;
  logic [3:0] prevEnables;
  logic [31:0] dwellCount;
  logic [31:0] next_dwellCount;
  logic [PSC_INT_W-1:0] intStatus;
  logic [PSC_INT_W-1:0] next_intStatus;
  logic [PSC_INT_W-1:0] intEnable;
  logic [PSC_INT_W-1:0] intEvents;
  logic [PSC_INT_W-1:0] intClear;
  logic seqControl;
  logic [PSC_SYNC_W-1:0] pinRaw;
  logic [PSC_SYNC_W-1:0] syncFirst;
  logic [PSC_SYNC_W-1:0] syncSecond;
  logic coreGoodS;
  logic analogueGoodS;
  logic pllGoodS;
  logic ioGoodS;
  logic coreErrorS;
  logic analogueErrorS;
  logic suppliesGood;
  logic dwellDone;
  logic stateChange;
  logic setupPhase;
  logic writeTaken;
  logic addrMapped;
  logic [31:0] readValue;
  logic [2:0] stateCode;

  // Pin inputs cross into clk through two flops each
  assign pinRaw = {analogueBuckError, coreBuckError, ioSupplyGood, pllGood, analogueGood, coreGood};

  generate
    for (genvar g = 0; g < PSC_SYNC_W; g++) begin : g_sync
      always_ff @(posedge clk) begin
        if (reset) begin
          syncFirst[g] <= 1'b0;
          syncSecond[g] <= 1'b0;
        end else begin
          syncFirst[g] <= pinRaw[g];
          syncSecond[g] <= syncFirst[g];
        end
      end
    end
  endgenerate

  assign coreGoodS = syncSecond[0];
  assign analogueGoodS = syncSecond[1];
  assign pllGoodS = syncSecond[2];
  assign ioGoodS = syncSecond[3];
  assign coreErrorS = syncSecond[4];
  assign analogueErrorS = syncSecond[5];

  function automatic logic [14:0] settingsFor(input psc_state_e st, input logic [31:0] cfg);
    logic [14:0] s;
    s = PSC_SET_RESET;
    case (st)
      PSC_ST_WAKING1: s = PSC_SET_WAKING1;
      PSC_ST_WAKING2: s = PSC_SET_WAKING2;
      PSC_ST_AWAKE_WAIT: s = PSC_SET_AWAKE;
      PSC_ST_AWAKE: s = PSC_SET_AWAKE;
      PSC_ST_SLEEPING1: s = PSC_SET_SLEEPING1;
      PSC_ST_SECOND_SLEEP_PHASE: s = cfg[14:0] & PSC_SETTING_MASK;
      PSC_ST_ASLEEP: s = PSC_SET_ASLEEP;
      default: s = PSC_SET_RESET;
    endcase
    return s;
  endfunction : settingsFor

  function automatic logic [2:0] codeFor(input psc_state_e st);
    logic [2:0] c;
    c = PSC_CODE_RESET;
    case (st)
      PSC_ST_ASLEEP: c = PSC_CODE_ASLEEP;
      PSC_ST_WAKING1: c = PSC_CODE_WAKING1;
      PSC_ST_WAKING2: c = PSC_CODE_WAKING2;
      PSC_ST_AWAKE_WAIT: c = PSC_CODE_AWAKE_WAIT;
      PSC_ST_AWAKE: c = PSC_CODE_AWAKE;
      PSC_ST_SLEEPING1: c = PSC_CODE_SLEEPING1;
      PSC_ST_SECOND_SLEEP_PHASE: c = PSC_CODE_SECOND_SLEEP;
      default: c = PSC_CODE_RESET;
    endcase
    return c;
  endfunction : codeFor

  // Every supply enabled in the current state must report good
  assign suppliesGood = (!applied[PSC_BIT_CORE_EN] || coreGoodS) &&
                        (!applied[PSC_BIT_ANALOGUE_EN] || analogueGoodS) &&
                        (!applied[PSC_BIT_PLL_EN] || pllGoodS) &&
                        (!applied[PSC_BIT_IO_EN] || ioGoodS);
  assign dwellDone = (dwellCount == 32'h0);

  always_comb begin
    nextState = state;
    case (state)
      PSC_ST_RESET: nextState = PSC_ST_WAKING1;
      PSC_ST_WAKING1: begin
        if (dwellDone && suppliesGood) begin
          nextState = PSC_ST_WAKING2;
        end
      end
      PSC_ST_WAKING2: begin
        if (dwellDone && suppliesGood) begin
          nextState = PSC_ST_AWAKE_WAIT;
        end
      end
      PSC_ST_AWAKE_WAIT: begin
        if (suppliesGood) begin
          nextState = PSC_ST_AWAKE;
        end
      end
      PSC_ST_AWAKE: begin
        if (seqControl) begin
          nextState = PSC_ST_SLEEPING1;
        end
      end
      PSC_ST_SLEEPING1: begin
        if (dwellDone && suppliesGood) begin
          nextState = PSC_ST_SECOND_SLEEP_PHASE;
        end
      end
      PSC_ST_SECOND_SLEEP_PHASE: begin
        if (dwellDone && suppliesGood) begin
          nextState = PSC_ST_ASLEEP;
        end
      end
      PSC_ST_ASLEEP: begin
        if (!seqControl) begin
          nextState = PSC_ST_WAKING1;
        end
      end
      default: nextState = PSC_ST_RESET;
    endcase
  end

  assign stateChange = (nextState != state);

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= PSC_ST_RESET;
    end else begin
      state <= nextState;
    end
  end

  // Counter holds remaining cycles minus one; loaded on entry
  always_comb begin
    next_dwellCount = dwellCount;
    if (stateChange) begin
      if (nextState == PSC_ST_SECOND_SLEEP_PHASE) begin
        next_dwellCount = (32'h1 << sleepCfg[PSC_DWELL_MSB:PSC_DWELL_LSB]) - 32'h1;
      end else begin
        next_dwellCount = (32'h1 << OTHER_DWELL_LOG2[4:0]) - 32'h1;
      end
    end else if (!dwellDone) begin
      next_dwellCount = dwellCount - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dwellCount <= 32'h0;
    end else begin
      dwellCount <= next_dwellCount;
    end
  end

  // Settings follow the state entered on the same edge
  assign next_applied = settingsFor(nextState, sleepCfg);

  always_ff @(posedge clk) begin
    if (reset) begin
      applied <= PSC_SET_RESET;
    end else begin
      applied <= next_applied;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prevEnables <= PSC_PREV_EN_RESET;
    end else if (stateChange) begin
      prevEnables <= {applied[PSC_BIT_IO_EN], applied[PSC_BIT_PLL_EN],
                      applied[PSC_BIT_ANALOGUE_EN], applied[PSC_BIT_CORE_EN]};
    end
  end

  assign tileClockStop = applied[PSC_BIT_TILE_STOP];
  assign analogueModulationPfm = applied[PSC_BIT_ANALOGUE_PFM];
  assign coreModulationPfm = applied[PSC_BIT_CORE_PFM];
  assign ioSupplyOutputEnable = applied[PSC_BIT_IO_EN];
  assign pllSupplyRegulatorEnable = applied[PSC_BIT_PLL_EN];
  assign coreBuckEnable = applied[PSC_BIT_CORE_EN];
  assign analogueBuckEnable = applied[PSC_BIT_ANALOGUE_EN];

  assign powerGoodLevel = convCtrl[PSC_CC_PGOOD_LSB +: 2];
  assign converterErrorClear = convCtrl[PSC_CC_ERR_CLEAR];
  assign analogueCurrentLimit = convCtrl[PSC_CC_ANA_ILIM_LSB +: 2];
  assign analogueSwitchClock = convCtrl[PSC_CC_ANA_CLK_LSB +: 2];
  assign coreCurrentLimit = convCtrl[PSC_CC_CORE_ILIM_LSB +: 2];
  assign coreSwitchClock = convCtrl[PSC_CC_CORE_CLK_LSB +: 2];

  // APB slave: zero wait states, answer registered at setup
  assign setupPhase = psel && !penable;
  assign writeTaken = psel && penable && pready && pwrite;
  assign stateCode = codeFor(state);

  always_comb begin
    addrMapped = 1'b1;
    readValue = 32'h0;
    case (paddr)
      PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG: readValue = sleepCfg;
      PSC_OFF_SEQUENCE_STATE_REPORT: begin
        readValue = {2'h0, prevEnables[3], prevEnables[2], 2'h0, prevEnables[1], prevEnables[0],
                     5'h0, stateCode, 1'b0, applied};
      end
      PSC_OFF_CONVERTER_CONTROL: readValue = convCtrl;
      PSC_OFF_INT_STATUS: readValue = {29'h0, intStatus};
      PSC_OFF_INT_CLEAR: readValue = 32'h0;
      PSC_OFF_INT_ENABLE: readValue = {29'h0, intEnable};
      PSC_OFF_SEQ_CONTROL: readValue = {31'h0, seqControl};
      default: addrMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !addrMapped;
      prdata <= (setupPhase && !pwrite) ? readValue : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sleepCfg <= PSC_CFG_RESET;
    end else if (writeTaken && paddr == PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG) begin
      sleepCfg <= (pwdata & PSC_CFG_WRITE_MASK) | PSC_CFG_FIXED_ONES;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      convCtrl <= PSC_CC_RESET;
    end else if (writeTaken && paddr == PSC_OFF_CONVERTER_CONTROL) begin
      convCtrl <= pwdata & PSC_CC_WRITE_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      seqControl <= 1'b0;
    end else if (writeTaken && paddr == PSC_OFF_SEQ_CONTROL) begin
      seqControl <= pwdata[PSC_CTRL_SLEEP_REQ];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      intEnable <= PSC_INT_RESET;
    end else if (writeTaken && paddr == PSC_OFF_INT_ENABLE) begin
      intEnable <= pwdata[PSC_INT_W-1:0];
    end
  end

  // Sticky events; a new event beats a write-one clear
  assign intEvents = {analogueErrorS, coreErrorS, stateChange};
  assign intClear = (writeTaken && paddr == PSC_OFF_INT_CLEAR) ? pwdata[PSC_INT_W-1:0] : PSC_INT_RESET;

  always_comb begin
    next_intStatus = (intStatus & ~intClear) | intEvents;
    if (convCtrl[PSC_CC_ERR_CLEAR]) begin
      next_intStatus[PSC_INT_CORE_ERROR] = 1'b0;
      next_intStatus[PSC_INT_ANALOGUE_ERROR] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      intStatus <= PSC_INT_RESET;
      irq <= 1'b0;
    end else begin
      intStatus <= next_intStatus;
      irq <= |(next_intStatus & intEnable);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_cfg_write;
    writeTaken && paddr == PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG;
  endsequence

  sequence s_stay_second_sleep;
    state == PSC_ST_SECOND_SLEEP_PHASE && nextState == PSC_ST_SECOND_SLEEP_PHASE;
  endsequence

  a_second_sleep_apply: assert property (s_stay_second_sleep |=>
    applied == ($past(sleepCfg[14:0]) & PSC_SETTING_MASK)) else $error("second sleep settings not applied");

  a_dwell_length: assert property ($rose(state == PSC_ST_SECOND_SLEEP_PHASE) &&
    sleepCfg[PSC_DWELL_MSB:PSC_DWELL_LSB] == 5'h2 |-> (state == PSC_ST_SECOND_SLEEP_PHASE) [*4])
    else $error("second sleep left before dwell");

  a_tile_stop_out: assert property (s_stay_second_sleep ##1 s_stay_second_sleep |->
    tileClockStop == $past(sleepCfg[PSC_BIT_TILE_STOP])) else $error("tile clock stop mismatch");

  a_modulation_out: assert property (s_stay_second_sleep ##1 s_stay_second_sleep |->
    {analogueModulationPfm, coreModulationPfm} == $past(sleepCfg[9:8])) else $error("modulation mismatch");

  a_supply_enables: assert property (s_stay_second_sleep |=>
    ioSupplyOutputEnable == $past(sleepCfg[PSC_BIT_IO_EN]) &&
    pllSupplyRegulatorEnable == $past(sleepCfg[PSC_BIT_PLL_EN]) &&
    coreBuckEnable == $past(sleepCfg[PSC_BIT_CORE_EN]))
    else $error("supply enables mismatch");

  a_analogue_fixed: assert property (s_cfg_write |=> sleepCfg[PSC_BIT_ANALOGUE_EN])
    else $error("analogue enable bit writable");

  a_prev_capture: assert property (stateChange |=>
    prevEnables == $past({ioSupplyOutputEnable, pllSupplyRegulatorEnable, analogueBuckEnable, coreBuckEnable}))
    else $error("previous enables not captured");

  a_report_state: assert property (setupPhase && !pwrite && paddr == PSC_OFF_SEQUENCE_STATE_REPORT |=>
    prdata[18:16] == $past(stateCode) && prdata[14:0] == $past(applied)) else $error("report read wrong");

  a_leave_good: assert property (stateChange && state != PSC_ST_RESET && state != PSC_ST_AWAKE &&
    state != PSC_ST_ASLEEP |-> suppliesGood) else $error("advanced with bad supply");

  a_err_held_clear: assert property (converterErrorClear [*2] |->
    intStatus[PSC_INT_ANALOGUE_ERROR:PSC_INT_CORE_ERROR] == 2'h0) else $error("error flag set while cleared");

  a_irq_level: assert property (##1 irq == |(intStatus & $past(intEnable)) || $past(stateChange)
    || $changed(intEnable)) else $error("irq does not follow status");

endmodule : psc_power_sequence_control

// file: test/psc_supply_model.sv
`timescale 1ns/10ps
module psc_supply_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic coreBuckEnable,
  input wire logic analogueBuckEnable,
  input wire logic pllSupplyRegulatorEnable,
  input wire logic ioSupplyOutputEnable,
  input wire logic slowStart,
  input wire logic [1:0] errorInject,
  output logic coreGood,
  output logic analogueGood,
  output logic pllGood,
  output logic ioSupplyGood,
  output logic coreBuckError,
  output logic analogueBuckError
);
  logic [3:0] enables;
  logic [4:0] age [4];
  logic [4:0] rampTime;
  assign enables = {ioSupplyOutputEnable, pllSupplyRegulatorEnable, analogueBuckEnable, coreBuckEnable};
  assign rampTime = slowStart ? 5'h14 : 5'h01;
  // Each supply ramps from its own enable; a disabled supply never reports good
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (reset || !enables[i]) begin
        age[i] <= 5'h00;
      end else if (age[i] != 5'h1f) begin
        age[i] <= age[i] + 5'h01;
      end
    end
  end
  assign coreGood = enables[0] && (age[0] >= rampTime);
  assign analogueGood = enables[1] && (age[1] >= rampTime);
  assign pllGood = enables[2] && (age[2] >= rampTime);
  assign ioSupplyGood = enables[3] && (age[3] >= rampTime);
  assign coreBuckError = errorInject[0];
  assign analogueBuckError = errorInject[1];
endmodule : psc_supply_model

// file: test/psc_power_sequence_control_bench.sv
`timescale 1ns/10ps
`define CHECK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin mismatches++; $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module psc_power_sequence_control_bench import psc_pkg::*;;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, slowStart;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic coreGood, analogueGood, pllGood, ioSupplyGood, coreBuckError, analogueBuckError;
  logic coreBuckEnable, analogueBuckEnable, pllSupplyRegulatorEnable, ioSupplyOutputEnable;
  logic coreModulationPfm, analogueModulationPfm, tileClockStop, converterErrorClear;
  logic [1:0] powerGoodLevel, analogueCurrentLimit, analogueSwitchClock, coreCurrentLimit, coreSwitchClock;
  logic [1:0] errorInject;
  int mismatches = 0;
  int samplesChecked = 0;
  int cycles = 0;

  psc_power_sequence_control #(.OTHER_DWELL_LOG2(2)) psc_power_sequence_control_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreGood(coreGood),
    .analogueGood(analogueGood), .pllGood(pllGood), .ioSupplyGood(ioSupplyGood),
    .coreBuckError(coreBuckError), .analogueBuckError(analogueBuckError), .coreBuckEnable(coreBuckEnable),
    .analogueBuckEnable(analogueBuckEnable), .pllSupplyRegulatorEnable(pllSupplyRegulatorEnable),
    .ioSupplyOutputEnable(ioSupplyOutputEnable), .coreModulationPfm(coreModulationPfm),
    .analogueModulationPfm(analogueModulationPfm), .tileClockStop(tileClockStop),
    .powerGoodLevel(powerGoodLevel), .converterErrorClear(converterErrorClear),
    .analogueCurrentLimit(analogueCurrentLimit), .analogueSwitchClock(analogueSwitchClock),
    .coreCurrentLimit(coreCurrentLimit), .coreSwitchClock(coreSwitchClock), .irq(irq));

  psc_supply_model psc_supply_model_inst (
    .clk(clk), .reset(reset), .coreBuckEnable(coreBuckEnable), .analogueBuckEnable(analogueBuckEnable),
    .pllSupplyRegulatorEnable(pllSupplyRegulatorEnable), .ioSupplyOutputEnable(ioSupplyOutputEnable),
    .slowStart(slowStart), .errorInject(errorInject), .coreGood(coreGood), .analogueGood(analogueGood),
    .pllGood(pllGood), .ioSupplyGood(ioSupplyGood), .coreBuckError(coreBuckError),
    .analogueBuckError(analogueBuckError));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the global cycle ceiling bounds this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] r;
    logic e;
    apb(1'b1, addr, data, r, e);
  endtask : wr

  task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, addr, 32'h00000000, r, e);
    `CHECK(r, exp)
  endtask : rdChk

  task automatic waitState(input logic [2:0] code);
    logic [31:0] r;
    logic e;
    int n;
    n = 0;
    do begin
      apb(1'b0, PSC_OFF_SEQUENCE_STATE_REPORT, 32'h00000000, r, e);
      n++;
    end while (r[18:16] !== code && n < 100);
    `CHECK(r[18:16], code)
  endtask : waitState

  task automatic waitEntry(output int n);
    n = 0;
    while (tileClockStop !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    n = 0;
  endtask : waitEntry

  task automatic countStay(output int n);
    n = 0;
    while (tileClockStop === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
  endtask : countStay

  task automatic resetValues;
    `CHECK(powerGoodLevel, 2'h2)
    `CHECK(analogueCurrentLimit, 2'h0)
    `CHECK(analogueSwitchClock, 2'h1)
    `CHECK(coreCurrentLimit, 2'h0)
    `CHECK(coreSwitchClock, 2'h1)
    `CHECK(tileClockStop, 1'b0)
  endtask : resetValues

  task automatic registerAccess;
    logic [31:0] r;
    logic e;
    logic [31:0] v;
    rdChk(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'h00100002);
    rdChk(PSC_OFF_CONVERTER_CONTROL, 32'h02000101);
    wr(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'hffffffff);
    rdChk(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'h001f4333);
    wr(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'h00000000);
    rdChk(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'h00000002);
    for (int c = 0; c < 4; c++) begin
      v = (32'(c) << 24) | (32'(c) << 13) | (32'(c) << 8) | (32'(c) << 5) | 32'(c);
      wr(PSC_OFF_CONVERTER_CONTROL, v);
      rdChk(PSC_OFF_CONVERTER_CONTROL, v);
      `CHECK({powerGoodLevel, analogueCurrentLimit, analogueSwitchClock}, {3{c[1:0]}})
      `CHECK({coreCurrentLimit, coreSwitchClock}, {2{c[1:0]}})
    end
    wr(PSC_OFF_CONVERTER_CONTROL, 32'hffffffff);
    rdChk(PSC_OFF_CONVERTER_CONTROL, 32'h03016363);
    `CHECK(converterErrorClear, 1'b1)
    wr(PSC_OFF_CONVERTER_CONTROL, 32'h02000101);
    apb(1'b0, 8'h10, 32'h00000000, r, e);
    `CHECK({e, r}, 33'h100000000)
  endtask : registerAccess

  task automatic promptSleep(input logic [4:0] dwell);
    int n;
    wr(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, {11'h000, dwell, 16'h4320});
    wr(PSC_OFF_SEQ_CONTROL, 32'h00000001);
    waitEntry(n);
    `CHECK({tileClockStop, analogueModulationPfm, coreModulationPfm}, 3'h7)
    `CHECK({ioSupplyOutputEnable, pllSupplyRegulatorEnable, analogueBuckEnable, coreBuckEnable}, 4'ha)
    countStay(n);
    `CHECK(n, 1 << dwell)
    rdChk(PSC_OFF_SEQUENCE_STATE_REPORT, 32'h22010000);
    wr(PSC_OFF_SEQ_CONTROL, 32'h00000000);
    waitState(3'h5);
  endtask : promptSleep

  task automatic slowSleep;
    int n;
    slowStart <= 1'b1;
    wr(PSC_OFF_SLEEP_TWO_SUPPLY_CONFIG, 32'h00024031);
    wr(PSC_OFF_SEQ_CONTROL, 32'h00000001);
    waitEntry(n);
    `CHECK({analogueModulationPfm, coreModulationPfm, pllSupplyRegulatorEnable}, 3'h1)
    rdChk(PSC_OFF_SEQUENCE_STATE_REPORT, 32'h22074033);
    countStay(n);
    `CHECK((n >= 14) && (n <= 40), 1'b1)
    rdChk(PSC_OFF_SEQUENCE_STATE_REPORT, 32'h33010000);
    slowStart <= 1'b0;
    wr(PSC_OFF_SEQ_CONTROL, 32'h00000000);
    waitState(3'h5);
  endtask : slowSleep

  task automatic errorIrq;
    int n;
    wr(PSC_OFF_INT_ENABLE, 32'h00000000);
    wr(PSC_OFF_INT_CLEAR, 32'h00000007);
    rdChk(PSC_OFF_INT_STATUS, 32'h00000000);
    wr(PSC_OFF_CONVERTER_CONTROL, 32'h02010101);
    errorInject <= 2'h3;
    repeat (8) @(posedge clk);
    rdChk(PSC_OFF_INT_STATUS, 32'h00000000);
    wr(PSC_OFF_CONVERTER_CONTROL, 32'h02000101);
    repeat (8) @(posedge clk);
    rdChk(PSC_OFF_INT_STATUS, 32'h00000006);
    `CHECK(irq, 1'b0)
    wr(PSC_OFF_INT_ENABLE, 32'h00000004);
    repeat (2) @(posedge clk);
    `CHECK(irq, 1'b1)
    errorInject <= 2'h0;
    repeat (8) @(posedge clk);
    wr(PSC_OFF_INT_CLEAR, 32'h00000006);
    rdChk(PSC_OFF_INT_STATUS, 32'h00000000);
    `CHECK(irq, 1'b0)
    wr(PSC_OFF_INT_ENABLE, 32'h00000001);
    wr(PSC_OFF_SEQ_CONTROL, 32'h00000001);
    n = 0;
    while (irq !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    `CHECK(irq, 1'b1)
  endtask : errorIrq

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    slowStart = 1'b0;
    errorInject = 2'h0;
    repeat (6) @(posedge clk);
    resetValues();
    reset <= 1'b0;
    registerAccess();
    waitState(3'h5);
    promptSleep(5'h00);
    promptSleep(5'h02);
    promptSleep(5'h03);
    slowSleep();
    errorIrq();
    end_sim();
  end
endmodule : psc_power_sequence_control_bench
